// *** node_addr_consts.svh ***
// constants for the node address switch selector
`ifndef NODE_ADDR_CONSTS_SVH
`define NODE_ADDR_CONSTS_SVH
`define DIGIT_W      4
`define ADDR_W       6
`define RAW_W        7
`define TENS_WEIGHT  7'h0A
`define UNITS_WEIGHT 7'h01
`define ADDR_MAX     7'h3F
`define RAW_MAX      7'h63
`define DIGIT_MAX    4'h9
`endif

// *** node_addr_pkg.sv ***
// types for the node address switch selector
package node_addr_pkg;
  `include "node_addr_consts.svh"

  typedef struct packed
  {
    logic [`DIGIT_W-1:0] tens;
    logic [`DIGIT_W-1:0] units;
  } switch_pair_s;

  typedef struct packed
  {
    logic [`ADDR_W-1:0] addr;
    logic               from_tool;
  } addr_result_s;

  typedef enum logic [1:0]
  {
    st_capture,
    st_run,
    st_fault
  } mon_state_e;

  typedef struct packed
  {
    mon_state_e         state;
    switch_pair_s       saved;
    logic [`ADDR_W-1:0] node_addr;
    logic               from_tool;
    logic               addr_valid;
    logic               fault;
    logic               bad_digit;
  } select_state_s;
endpackage : node_addr_pkg

// *** switch_decode.sv ***
// combinational decode of the two rotary digits into a node address
`timescale 1ns/1ps
module switch_decode
  import node_addr_pkg::*;
(
  // switch digits
  input  node_addr_pkg::switch_pair_s sw,
  // tool address
  input  wire logic [`ADDR_W-1:0]     tool_addr,
  // decoded result
  output node_addr_pkg::addr_result_s res,
  output logic                        bad_digit
);
  // one bit wider than a decimal pair needs: two undecimal digits reach 165 and must not wrap
  logic [`RAW_W:0] raw;

  always_comb
  begin
    raw = {4'h0, sw.tens} * 8'(`TENS_WEIGHT) + {4'h0, sw.units} * 8'(`UNITS_WEIGHT);
    bad_digit = (sw.tens > `DIGIT_MAX) || (sw.units > `DIGIT_MAX);
    if (raw <= `ADDR_MAX)
    begin
      res.addr      = raw[`ADDR_W-1:0];
      res.from_tool = 1'b0;
    end
    else
    begin
      // 64..165, including undecimal codes whose weighted sum exceeds 63, defer to the tool's address
      res.addr      = tool_addr;
      res.from_tool = 1'b1;
    end
  end
endmodule : switch_decode

// *** node_address_switch_select.sv ***
// node address selection from rotary switches with change monitoring
//
// Behaviour
// - the raw value is the left digit times ten plus the right digit.
// - a raw value of 0 to 63 is used directly as the node address.
// - a raw value of 64 to 99 is ignored and the tool-written address is used.
// - any switch change seen on an enabled edge after the snapshot latches the fault halt state.
// - the fault stays until reset is applied; restoring the switches alone does not clear it.
`timescale 1ns/1ps
module node_address_switch_select
  import node_addr_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  // rotary switches
  input  node_addr_pkg::switch_pair_s sw,
  // address stored by the configuration tool
  input  wire logic [`ADDR_W-1:0]     tool_addr,
  // results
  output logic [`ADDR_W-1:0]          node_addr,
  output logic                        from_tool,
  output logic                        addr_valid,
  output logic                        fault,
  output logic                        bad_digit
);
  import node_addr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  select_state_s cur;
  select_state_s next_cur;
  addr_result_s  res;
  logic          dec_bad;
  logic [1:0]    digit_moved;
  logic          sw_moved;

  ////////////////////////////////////////////////////////////////////////
  // a digit counts as moved when its live code differs from the snapshot
  function automatic logic digit_differs
  (
    input logic [`DIGIT_W-1:0] live,
    input logic [`DIGIT_W-1:0] kept
  );
    return live != kept;
  endfunction : digit_differs

  ////////////////////////////////////////////////////////////////////////
  // each digit watched on its own, so a one-step turn of either switch trips
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_digit
      assign digit_moved[gi] = digit_differs(sw[gi*`DIGIT_W +: `DIGIT_W],
                                             cur.saved[gi*`DIGIT_W +: `DIGIT_W]);
    end
  endgenerate

  assign sw_moved = |digit_moved;

  switch_decode switch_decode_i
  (
    .sw        (sw),
    .tool_addr (tool_addr),
    .res       (res),
    .bad_digit (dec_bad)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_cur = cur;
    unique case (cur.state)
      st_capture:
      begin
        // snapshot taken on the first enabled edge after reset release
        next_cur.saved      = sw;
        next_cur.node_addr  = res.addr;
        next_cur.from_tool  = res.from_tool;
        next_cur.bad_digit  = dec_bad;
        next_cur.addr_valid = 1'b1;
        next_cur.state      = st_run;
      end
      st_run:
      begin
        // tool address may be rewritten at run time when switches defer
        if (cur.from_tool)
        begin
          next_cur.node_addr = tool_addr;
        end
        if (sw_moved)
        begin
          next_cur.fault      = 1'b1;
          next_cur.addr_valid = 1'b0;
          next_cur.state      = st_fault;
        end
      end
      st_fault:
      begin
        // only reset leaves here; restoring the switches alone is not enough
        next_cur.fault      = 1'b1;
        next_cur.addr_valid = 1'b0;
      end
      default:
      begin
        next_cur.state = st_fault;
        next_cur.fault = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur <= '{state: st_capture, saved: '0, node_addr: '0, from_tool: 1'b0,
               addr_valid: 1'b0, fault: 1'b0, bad_digit: 1'b0};
    end
    else if (clk_en)
    begin
      cur <= next_cur;
    end
  end

  assign node_addr  = cur.node_addr;
  assign from_tool  = cur.from_tool;
  assign addr_valid = cur.addr_valid;
  assign fault      = cur.fault;
  assign bad_digit  = cur.bad_digit;
endmodule : node_address_switch_select

// *** sw_model.sv ***
// switch, tool and power model for the selector
`timescale 1ns/1ps
module sw_model
  import node_addr_pkg::*;
(
  // clock and wanted levels
  input logic ref_clk,
  input logic [15:0] want,
  // levels at the design
  output logic sys_rst,
  output logic clk_en,
  output node_addr_pkg::switch_pair_s sw,
  output logic [5:0] tool_addr
);
  // starts in reset so the design never runs on unknowns
  initial {sys_rst, clk_en, sw, tool_addr} = 16'h8000;
  always @(posedge ref_clk)
    #1 {sys_rst, clk_en, sw, tool_addr} <= want;
endmodule : sw_model

// *** node_address_switch_select_properties.sv ***
// checker for the address selector
`timescale 1ns/1ps
module sel_props
  import node_addr_pkg::*;
(
  // clock and reset
  input logic ref_clk,
  input logic sys_rst,
  input logic clk_en,
  // inputs
  input node_addr_pkg::switch_pair_s sw,
  input logic [5:0] tool_addr,
  // results
  input logic [5:0] node_addr,
  input logic from_tool,
  input logic addr_valid,
  input logic fault,
  input logic bad_digit
);
  switch_pair_s cap;
  wire [7:0] raw = {4'h0, cap.tens} * 8'h0A + {4'h0, cap.units};
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst) cap <= '0;
    else if (clk_en && !addr_valid && !fault) cap <= sw;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  fault_latch_a: assert property (fault |=> fault) else $error("fault dropped");
  fault_halt_a: assert property (fault |-> !addr_valid) else $error("valid in fault");
  change_trip_a: assert property (addr_valid && clk_en && sw != cap |=> fault) else $error("missed");
  same_keep_a: assert property (addr_valid && clk_en && sw == cap |=> addr_valid) else $error("false");
  direct_addr_a: assert property (addr_valid && raw <= 8'h3F |-> node_addr == raw[5:0] && !from_tool) else $error("addr");
  tool_pick_a: assert property (addr_valid && raw > 8'h3F |-> from_tool) else $error("no tool");
  tool_follow_a: assert property (from_tool && clk_en |=> !addr_valid || node_addr == $past(tool_addr)) else $error("lag");
  freeze_hold_a: assert property (!clk_en |=> $stable({node_addr, fault})) else $error("moved");
  cover property (fault);
  cover property (from_tool);
  cover property (addr_valid && !from_tool);
  cover property (addr_valid && bad_digit);
endmodule : sel_props
bind node_address_switch_select sel_props sel_props_i
(
  .ref_clk    (ref_clk),
  .sys_rst    (sys_rst),
  .clk_en     (clk_en),
  .sw         (sw),
  .tool_addr  (tool_addr),
  .node_addr  (node_addr),
  .from_tool  (from_tool),
  .addr_valid (addr_valid),
  .fault      (fault),
  .bad_digit  (bad_digit)
);

// *** test_node_address_switch_select.sv ***
// bench for the address selector
`timescale 1ns/1ps
module test_node_address_switch_select;
  import node_addr_pkg::*;
  logic ref_clk = 0, sys_rst, clk_en, from_tool, addr_valid, fault, bad_digit;
  logic [5:0] tool_addr, node_addr;
  switch_pair_s sw;
  logic [15:0] w = 16'h8000;
  logic [9:0] q[$], got;
  logic [6:0] e[6] = '{7'h00, 7'h3F, 7'h40, 7'h63, 7'h09, 7'h5A};
  int error_cnt = 0, n_tests = 0, seed = 32'hC00E;
  sw_model sw_model_i
  (
    .ref_clk   (ref_clk),
    .want      (w),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .sw        (sw),
    .tool_addr (tool_addr)
  );
  node_address_switch_select node_address_switch_select_i
  (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .sw         (sw),
    .tool_addr  (tool_addr),
    .node_addr  (node_addr),
    .from_tool  (from_tool),
    .addr_valid (addr_valid),
    .fault      (fault),
    .bad_digit  (bad_digit)
  );
  initial forever #25 ref_clk = ~ref_clk;
  initial #100us test_done(1);
  always @(posedge addr_valid or posedge fault)
  begin
    #1 got = q.pop_front();
    n_tests++;
    if (got[9:8] !== {addr_valid, fault} || got[9] && got !== {addr_valid, fault, node_addr, from_tool, bad_digit})
    begin
      error_cnt++;
      $display("BAD %0t want %h", $time, got);
    end
  end
  task test_done(input int late);
    error_cnt += late;
    $display("%0d checks, %0d bad", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task run(input logic [3:0] tens, input logic [3:0] units);
    int r;
    r = tens * 10 + units;
    @(negedge ref_clk) w = {2'h3, tens, units, 6'($random(seed))};
    repeat (2) @(negedge ref_clk);
    q.push_back({2'h2, r > 63 ? w[5:0] : 6'(r), r > 63, tens > 4'h9 || units > 4'h9});
    w[15] = 1'h0;
    // stalls and tool rewrites only after the capture edge
    repeat (6) @(negedge ref_clk) {w[14], w[5:0]} = 7'($random(seed));
    q.push_back(10'h100);
    @(negedge ref_clk) w[14:6] = {1'h1, w[13:6] ^ 8'h01};
    repeat (4) @(negedge ref_clk);
    w[6] = ~w[6];
    repeat (4) @(negedge ref_clk);
    n_tests++;
    if (fault !== 1'h1)
    begin
      error_cnt++;
      $display("BAD %0t fault cleared by restore", $time);
    end
    $display("done %0d", r);
  endtask : run
  initial
  begin
    repeat (20) @(negedge ref_clk);
    foreach (e[i]) run(4'(e[i] / 7'h0A), 4'(e[i] % 7'h0A));
    repeat (6) run(4'($unsigned($random(seed)) % 10), 4'($unsigned($random(seed)) % 10));
    run(4'hC, 4'h3);
    run(4'h2, 4'hF);
    run(4'hF, 4'hF);
    repeat (2) run(4'($random(seed)), 4'($random(seed)));
    test_done(0);
  end
endmodule : test_node_address_switch_select
